// ===== include/psram_ctrl_pkg.sv
// shared constants, codes and pin bundle of the pseudo-static memory host
package psram_ctrl_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 16;
    localparam int TMR_W         = 13;
    localparam int SYNC_CYC      = 2;

    localparam int T_CYCLE_NS = 70;
    localparam int T_ZZWE_NS  = 10;
    localparam int T_ZZ_US    = 10;
    localparam int T_INIT_US  = 150;
    localparam int ACC_CYC    =
        (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ZZWE_CYC   =
        (T_ZZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // sleep entry needs the pin low strictly longer than the minimum
    localparam int ZZ_CYC     = T_ZZ_US * 1000 / CLK_PERIOD_NS + 1;
    localparam int INIT_CYC   =
        (T_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_CFG    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0C;
    localparam logic [7:0] REG_ADDR   = 8'h10;
    localparam logic [7:0] REG_WDATA  = 8'h14;

    localparam int CFG_PAGE_BIT  = 7;
    localparam int CFG_TEMP_LSB  = 5;
    localparam int CFG_SLEEP_BIT = 4;
    localparam int CFG_PART_LSB  = 0;
    localparam logic [ADDR_W-1:0] CFG_USED_MASK = 20'h000F7;
    localparam logic [ADDR_W-1:0] CFG_RESET     = 20'h00070;
    localparam logic [1:0] TEMP_85C  = 2'h3;
    localparam logic [1:0] TEMP_70C  = 2'h0;
    localparam logic [1:0] TEMP_45C  = 2'h1;
    localparam logic [1:0] TEMP_15C  = 2'h2;
    localparam logic [2:0] PART_FULL = 3'h0;
    localparam logic [2:0] PART_NONE = 3'h4;
    localparam logic [ADDR_W-1:0] SOFT_ADDR_DEF = 20'hFFFFF;

    localparam int ST_BUSY    = 0;
    localparam int ST_ASLEEP  = 1;
    localparam int ST_INIT    = 2;
    localparam int ST_SOFT    = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_INVALID = 5;
    localparam int ST_PAGE    = 6;

    typedef enum logic [2:0] {
        C_NONE     = 3'h0,
        C_PIN_LOAD = 3'h1,
        C_SOFT_WR  = 3'h2,
        C_SOFT_RD  = 3'h3,
        C_SLEEP    = 3'h4,
        C_WAKE     = 3'h5,
        C_MEM_RD   = 3'h6,
        C_MEM_WR   = 3'h7
    } cmd_t;

    typedef enum logic [2:0] {
        S_IDLE       = 3'h0,
        S_ZZ_SETUP   = 3'h1,
        S_STROBE     = 3'h3,
        S_RECOV      = 3'h2,
        S_SLEEP_HOLD = 3'h6,
        S_ASLEEP     = 3'h7,
        S_INIT_WAIT  = 3'h5
    } state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] dq_o;
        logic              dq_oe;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic              lb_n;
        logic              ub_n;
        logic              low_power_request_n;
    } pins_t;

    localparam pins_t PINS_IDLE = '{a: 20'h00000, dq_o: 16'h0000,
        dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, lb_n: 1'b1,
        ub_n: 1'b1, low_power_request_n: 1'b1};
endpackage

// ===== hw/cycle_timer.sv
// down-counting cycle timer with an expiry level
`timescale 1ns/100ps
module cycle_timer #(
    parameter int W = 13
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              expired_o
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    assign nxt_cnt   = load_i ? count_i :
                       (cnt_ff == '0) ? cnt_ff : cnt_ff - 1'b1;
    assign expired_o = (cnt_ff == '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// ===== hw/psram_cfg_host.sv
// host controller that configures and sleeps a pseudo-static memory
`timescale 1ns/100ps
// What this block does
// - Host writes zero into reserved bits 19:8 and 3.
// - Deep power-down is changed only by pin loads, never software.
// - After deep power-down exit, wait 150 us before normal accesses.
// - Temperature setting must be at or above case temperature.
// - Power pin low over 10 us enters sleep; high exits it.
// - Pin load: pin falls, then a write latches address into config.
// - Soft access: two reads, two writes at top address, or read last.
module psram_cfg_host
    import psram_ctrl_pkg::*;
#(
    parameter int                INIT_CYCLES = INIT_CYC,
    parameter logic [ADDR_W-1:0] SOFT_ADDR   = SOFT_ADDR_DEF
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [7:0]        paddr_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output pins_t                  pins_o,
    input  wire logic [DATA_W-1:0] dq_i
);
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    localparam logic [TMR_W-1:0] WR_LEN   = TMR_W'(ACC_CYC - 1);
    localparam logic [TMR_W-1:0] RD_LEN   = TMR_W'(ACC_CYC + SYNC_CYC - 1);
    localparam logic [TMR_W-1:0] ZZWE_LEN = TMR_W'(ZZWE_CYC - 1);
    localparam logic [TMR_W-1:0] ZZ_LEN   = TMR_W'(ZZ_CYC - 1);
    localparam logic [TMR_W-1:0] INIT_LEN = TMR_W'(INIT_CYCLES - 1);

    state_t              state_ff;
    state_t              nxt_state;
    cmd_t                op_ff;
    logic [1:0]          step_ff;
    logic [1:0]          nxt_step;
    pins_t               pins_ff;
    pins_t               nxt_pins;
    logic [ADDR_W-1:0]   cfg_ff;
    logic [ADDR_W-1:0]   shadow_ff;
    logic [ADDR_W-1:0]   addr_ff;
    logic [DATA_W-1:0]   wdata_ff;
    logic [DATA_W-1:0]   rdata_ff;
    logic [DATA_W-1:0]   dq_meta_ff;
    logic [DATA_W-1:0]   dq_sync_ff;
    logic                soft_ff;
    logic                refused_ff;
    logic                invalid_ff;
    logic                pready_ff;
    logic [31:0]         prdata_ff;
    logic                pslverr_ff;
    logic                tmr_load;
    logic [TMR_W-1:0]    tmr_count;
    logic                tmr_done;
    logic                begin_acc;

    // register bus decode
    wire        acc_en     = psel_i & penable_i & pready_ff;
    wire        wr_en      = acc_en & pwrite_i;
    wire        hit_cmd    = (paddr_i == REG_CMD);
    wire        hit_cfg    = (paddr_i == REG_CFG);
    wire        hit_status = (paddr_i == REG_STATUS);
    wire        hit_rdata  = (paddr_i == REG_RDATA);
    wire        hit_addr   = (paddr_i == REG_ADDR);
    wire        hit_wdata  = (paddr_i == REG_WDATA);
    wire        mapped     = hit_cmd | hit_cfg | hit_status | hit_rdata |
                             hit_addr | hit_wdata;
    wire        idle       = (state_ff == S_IDLE);
    // page mode is a property of the device; the host only reports it
    wire        page_on    = shadow_ff[CFG_PAGE_BIT];
    wire [6:0]  status_v   = {page_on, invalid_ff, refused_ff, soft_ff,
                              state_ff == S_INIT_WAIT,
                              state_ff == S_ASLEEP, !idle};
    wire [31:0] rd_mux     =
        hit_cfg    ? {12'h000, cfg_ff}   :
        hit_status ? {25'h0, status_v} :
        hit_rdata  ? {16'h0000, rdata_ff} :
        hit_addr   ? {12'h000, addr_ff}  :
        hit_wdata  ? {16'h0000, wdata_ff} : 32'h00000000;

    // command acceptance
    wire        cmd_wr     = wr_en & hit_cmd;
    wire cmd_t  cmd_code   = cmd_t'(pwdata_i[2:0]);
    wire        dpd_change = cfg_ff[CFG_SLEEP_BIT] !=
                             shadow_ff[CFG_SLEEP_BIT];
    wire        cmd_ok     = (cmd_code == C_WAKE) ?
                             (state_ff == S_ASLEEP) :
                             (idle && cmd_code != C_NONE &&
                              !(cmd_code == C_SOFT_WR && dpd_change));
    wire        start      = cmd_wr & cmd_ok;
    wire        refuse     = cmd_wr & ~cmd_ok;
    wire        st_clr     = wr_en & hit_status;

    // what the next access on the pins looks like
    wire cmd_t  acc_op     = idle ? cmd_code : op_ff;
    wire [1:0]  acc_step   = (state_ff == S_RECOV) ? step_ff + 2'h1 : 2'h0;
    wire        acc_soft   = (acc_op == C_SOFT_WR) || (acc_op == C_SOFT_RD);
    wire        acc_read   = acc_soft ?
        (acc_step < 2'h2 || (acc_step == 2'h3 && acc_op == C_SOFT_RD)) :
        (acc_op == C_MEM_RD);
    wire [ADDR_W-1:0] acc_addr = (acc_op == C_PIN_LOAD) ? cfg_ff :
                                 acc_soft ? SOFT_ADDR : addr_ff;
    wire [DATA_W-1:0] acc_wdata = acc_soft ? cfg_ff[DATA_W-1:0] : wdata_ff;

    wire        cur_soft   = (op_ff == C_SOFT_WR) || (op_ff == C_SOFT_RD);
    wire        last_step  = cur_soft ? (step_ff == 2'h3) : 1'b1;
    wire        acc_end    = (state_ff == S_STROBE) && tmr_done;
    wire        cfg_commit = acc_end && last_step &&
                             (op_ff == C_PIN_LOAD || op_ff == C_SOFT_WR);
    wire        enter_dpd  = (state_ff == S_SLEEP_HOLD) && tmr_done &&
                             !shadow_ff[CFG_SLEEP_BIT];

    cycle_timer #(
        .W         (TMR_W)
    ) u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .expired_o (tmr_done)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_pins  = pins_ff;
        nxt_step  = step_ff;
        tmr_load  = 1'b0;
        tmr_count = '0;
        begin_acc = 1'b0;
        unique case (state_ff)
            S_IDLE: begin
                if (start && cmd_code == C_PIN_LOAD) begin
                    nxt_pins.low_power_request_n = 1'b0;
                    nxt_state = S_ZZ_SETUP;
                    tmr_load  = 1'b1;
                    tmr_count = ZZWE_LEN;
                end else if (start && cmd_code == C_SLEEP) begin
                    nxt_pins.low_power_request_n = 1'b0;
                    nxt_state = S_SLEEP_HOLD;
                    tmr_load  = 1'b1;
                    tmr_count = ZZ_LEN;
                end else if (start) begin
                    begin_acc = 1'b1;
                end
            end
            S_ZZ_SETUP: begin
                begin_acc = tmr_done;
            end
            S_STROBE: begin
                if (tmr_done) begin
                    nxt_pins.ce_n  = 1'b1;
                    nxt_pins.we_n  = 1'b1;
                    nxt_pins.oe_n  = 1'b1;
                    nxt_pins.dq_oe = 1'b0;
                    nxt_state      = S_RECOV;
                end
            end
            S_RECOV: begin
                if (!last_step) begin
                    begin_acc = 1'b1;
                end else begin
                    nxt_pins.low_power_request_n = 1'b1;
                    nxt_state = S_IDLE;
                end
            end
            S_SLEEP_HOLD: begin
                if (tmr_done) begin
                    nxt_state = S_ASLEEP;
                end
            end
            S_ASLEEP: begin
                if (start) begin
                    nxt_pins.low_power_request_n = 1'b1;
                    if (!shadow_ff[CFG_SLEEP_BIT]) begin
                        nxt_state = S_INIT_WAIT;
                        tmr_load  = 1'b1;
                        tmr_count = INIT_LEN;
                    end else begin
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_INIT_WAIT: begin
                if (tmr_done) begin
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_IDLE;
                nxt_pins  = PINS_IDLE;
            end
        endcase
        if (begin_acc) begin
            nxt_state      = S_STROBE;
            nxt_step       = acc_step;
            nxt_pins.a     = acc_addr;
            nxt_pins.dq_o  = acc_wdata;
            nxt_pins.dq_oe = !acc_read;
            nxt_pins.ce_n  = 1'b0;
            nxt_pins.we_n  = acc_read;
            nxt_pins.oe_n  = !acc_read;
            nxt_pins.lb_n  = 1'b0;
            nxt_pins.ub_n  = 1'b0;
            tmr_load       = 1'b1;
            tmr_count      = acc_read ? RD_LEN : WR_LEN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= S_IDLE;
            op_ff    <= C_NONE;
            step_ff  <= 2'h0;
            pins_ff  <= PINS_IDLE;
        end else begin
            state_ff <= nxt_state;
            op_ff    <= (idle && start) ? cmd_code : op_ff;
            step_ff  <= nxt_step;
            pins_ff  <= nxt_pins;
        end
    end

    // bus-side registers; reserved config bits are cleared on entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff   <= CFG_RESET;
            addr_ff  <= '0;
            wdata_ff <= '0;
        end else if (wr_en && idle) begin
            if (hit_cfg) begin
                cfg_ff <= pwdata_i[ADDR_W-1:0] &
                          CFG_USED_MASK;
            end
            if (hit_addr) begin
                addr_ff <= pwdata_i[ADDR_W-1:0];
            end
            if (hit_wdata) begin
                wdata_ff <= pwdata_i[DATA_W-1:0];
            end
        end
    end

    // device config as last loaded, and sticky status flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow_ff  <= CFG_RESET;
            soft_ff    <= 1'b0;
            refused_ff <= 1'b0;
            invalid_ff <= 1'b0;
            rdata_ff   <= '0;
        end else begin
            shadow_ff  <= cfg_commit ? cfg_ff : shadow_ff;
            soft_ff    <= soft_ff |
                          (cfg_commit && op_ff == C_SOFT_WR);
            refused_ff <= refuse | (refused_ff & ~(st_clr &
                          pwdata_i[ST_REFUSED]));
            invalid_ff <= enter_dpd | (invalid_ff & ~(st_clr &
                          pwdata_i[ST_INVALID]));
            if (acc_end && !pins_ff.oe_n) begin
                rdata_ff <= dq_sync_ff;
            end
        end
    end

    // data pins come from outside the clock domain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_meta_ff <= '0;
            dq_sync_ff <= '0;
        end else begin
            dq_meta_ff <= dq_i;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    // zero-wait slave: ready in every access phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel_i & ~penable_i;
            prdata_ff  <= rd_mux;
            pslverr_ff <= psel_i & ~penable_i & ~mapped;
        end
    end

    assign prdata_o  = prdata_ff;
    assign pready_o  = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign pins_o    = pins_ff;

    // helper counters for the checks below
    logic [15:0] zz_low_cnt_ff;
    logic [15:0] init_cnt_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zz_low_cnt_ff <= '0;
            init_cnt_ff   <= '0;
        end else begin
            zz_low_cnt_ff <= pins_ff.low_power_request_n ? 16'h0000 :
                             zz_low_cnt_ff + 16'h0001;
            init_cnt_ff   <= (state_ff == S_INIT_WAIT) ?
                             init_cnt_ff + 16'h0001 : 16'h0000;
        end
    end

    a_pin_load_zero: assert property (
        (state_ff == S_STROBE && op_ff == C_PIN_LOAD) |->
        (pins_ff.a[19:8] == 12'h000 && !pins_ff.a[3]))
        else $error("pin load drives a reserved bit high");
    a_soft_keeps_sleep: assert property (
        (state_ff == S_STROBE && op_ff == C_SOFT_WR && step_ff[1]) |->
        (pins_ff.dq_o[CFG_SLEEP_BIT] == shadow_ff[CFG_SLEEP_BIT]))
        else $error("software load changes the sleep mode");
    a_soft_top_addr: assert property (
        (state_ff == S_STROBE && cur_soft) |-> (pins_ff.a == SOFT_ADDR))
        else $error("software sequence off the top address");
    a_soft_reads_first: assert property (
        (state_ff == S_STROBE && cur_soft && step_ff < 2'h2) |->
        (!pins_ff.oe_n && pins_ff.we_n))
        else $error("software sequence does not open with reads");
    a_sleep_hold: assert property (
        $rose(state_ff == S_ASLEEP) |->
        (zz_low_cnt_ff >= ZZ_CYC && !pins_ff.low_power_request_n))
        else $error("sleep reached with power pin low too briefly");
    a_init_length: assert property (
        ($past(state_ff) == S_INIT_WAIT && state_ff != S_INIT_WAIT) |->
        (init_cnt_ff == INIT_CYCLES))
        else $error("recovery wait has the wrong length");
    a_init_no_access: assert property (
        (state_ff == S_INIT_WAIT) |-> (pins_ff.ce_n && pins_ff.we_n))
        else $error("access during recovery wait");
    a_load_after_fall: assert property (
        (state_ff == S_ZZ_SETUP) |->
        ##[1:4] (!pins_ff.we_n && !pins_ff.ce_n &&
                 !pins_ff.low_power_request_n))
        else $error("no write follows the power pin fall");
    a_write_width: assert property (
        $fell(pins_ff.we_n) |-> (!pins_ff.we_n) [*4] ##1 pins_ff.we_n)
        else $error("write strobe width wrong");
endmodule

// ===== tb/psram_dev_model.sv
// behavioural pseudo-static memory with its configuration word
`timescale 1ns/100ps
module psram_dev_model
    import psram_ctrl_pkg::*;
#(
    parameter real T_INIT_NS = 400.0
) (
    input  wire pins_t             pins_i,
    output logic [DATA_W-1:0]      dq_o,
    output logic [ADDR_W-1:0]      cfg_o,
    output logic                   soft_o,
    output logic                   dpd_o,
    output logic                   par_o,
    output logic                   full_o,
    output int                     early_o,
    output logic [DATA_W-1:0]      wlast_o
);
    logic [2:0]  hist;
    logic [1:0]  nops;
    logic        armed;
    logic        wr;
    logic [15:0] wlast;
    realtime     t_low;
    realtime     t_ready;
    wire top = pins_i.a == SOFT_ADDR_DEF;
    wire fourth = top && nops == 2'h3 && hist == 3'h1;
    assign full_o = cfg_o[2:0] != 3'h4;
    assign wlast_o = wlast;
    initial begin
        cfg_o = 20'h00070;
        soft_o = 1'b0;
        dpd_o = 1'b0;
        par_o = 1'b0;
        early_o = 0;
        nops = 2'h0;
        hist = 3'h0;
        armed = 1'b0;
        wr = 1'b0;
        t_low = 0.0;
        t_ready = 0.0;
        dq_o = 16'h5A5A;
    end
    // an undriven bus shows a changing pattern, never the last value
    always @(pins_i) begin
        if (!pins_i.ce_n) wr = !pins_i.we_n;
        if (!pins_i.we_n) wlast = pins_i.dq_o;
        if (!pins_i.ce_n && !pins_i.oe_n)
            dq_o = fourth ? cfg_o[15:0] : ~pins_i.a[15:0];
        else
            dq_o = ~dq_o;
    end
    always @(negedge pins_i.ce_n) begin
        if (dpd_o || $realtime < t_ready) early_o++;
    end
    always @(posedge pins_i.ce_n) begin
        if (armed && !pins_i.low_power_request_n && wr) begin
            cfg_o = pins_i.a;
        end else if (fourth && wr) begin
            cfg_o[15:0] = wlast;
            soft_o = 1'b1;
        end
        armed = 1'b0;
        hist = top ? {hist[1:0], wr} : 3'h0;
        nops = (!top || nops == 2'h3) ? 2'h0 : nops + 2'h1;
    end
    always @(negedge pins_i.low_power_request_n) begin
        armed = 1'b1;
        t_low = $realtime;
    end
    always @(posedge pins_i.low_power_request_n) begin
        if (dpd_o) begin
            dpd_o = 1'b0;
            t_ready = $realtime + T_INIT_NS;
        end
    end
    always begin
        #10;
        if (!pins_i.low_power_request_n &&
            $realtime - t_low > 10000.0) begin
            if (!cfg_o[4]) dpd_o = 1'b1;
            else if (!soft_o) par_o = 1'b1;
        end
    end
endmodule

// ===== tb/psram_cfg_host_test.sv
// self-checking bench of the memory configuration host
`timescale 1ns/100ps
module psram_cfg_host_test;
    import psram_ctrl_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              psel_i = 1'b0;
    logic              penable_i = 1'b0;
    logic              pwrite_i = 1'b0;
    logic [7:0]        paddr_i = 8'h00;
    logic [31:0]       pwdata_i = 32'h0;
    logic [31:0]       prdata_o;
    logic [31:0]       rd;
    logic              pready_o;
    logic              pslverr_o;
    logic              serr;
    pins_t             pins_o;
    logic [DATA_W-1:0] dq_i;
    logic [DATA_W-1:0] mdq;
    logic [DATA_W-1:0] mwl;
    logic [ADDR_W-1:0] mcfg;
    logic [ADDR_W-1:0] val;
    logic [ADDR_W-1:0] exp;
    logic              msoft;
    logic              mdpd;
    logic              mpar;
    logic              mfull;
    int                mearly;
    int                err_total = 0;
    int                checked = 0;
    int                seed = 32'ha18309f5;
    assign dq_i = pins_o.dq_oe ? pins_o.dq_o : mdq;
    always #10 clk_i = ~clk_i;
    psram_cfg_host #(.INIT_CYCLES(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pins_o(pins_o),
        .dq_i(dq_i));
    psram_dev_model #(.T_INIT_NS(400.0)) dev_u (.pins_i(pins_o), .dq_o(mdq),
        .cfg_o(mcfg), .soft_o(msoft), .dpd_o(mdpd), .par_o(mpar),
        .full_o(mfull), .early_o(mearly), .wlast_o(mwl));
    function automatic logic [19:0] msk(input logic [19:0] v);
        return {12'h000, v[7:4], 1'b0, v[2:0]};
    endfunction
    task end_of_test;
        $display("errors %0d compares %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            err_total++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, want);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            err_total++;
            end_of_test;
        end
        rd = prdata_o;
        serr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // poll one status bit until it reaches the wanted level
    task wait_st(input int b, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[b] !== v && n < lim);
        if (rd[b] !== v) begin
            err_total++;
            end_of_test;
        end
    endtask
    task cmd(input cmd_t c);
        apb(1'b1, REG_CMD, {29'h0, c});
        wait_st(ST_BUSY, 1'b0, 200);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(1'b0, REG_CFG, 32'h0);
        cmp(rd, 32'h00000070);
        apb(1'b0, 8'h20, 32'h0);
        cmp({31'h0, serr}, 32'h1);
        // every refresh and temperature code, reserved bit 3 set, reserved bits 19:8 random
        for (int i = 0; i < 8; i++) begin
            val = 20'($random(seed));
            val[6:0] = {i[1:0], 2'h3, i[2:0]};
            exp = msk(val);
            apb(1'b1, REG_CFG, {12'hFFF, val});
            apb(1'b0, REG_CFG, 32'h0);
            cmp(rd, {12'h000, exp});
            cmd(C_PIN_LOAD);
            cmp({12'h000, mcfg}, {12'h000, exp});
            cmp({31'h0, mfull}, {31'h0, exp[2:0] != 3'h4});
            cmp({31'h0, rd[ST_PAGE]}, {31'h0, exp[7]});
        end
        cmd(C_SOFT_RD);
        apb(1'b0, REG_RDATA, 32'h0);
        cmp(rd, {16'h0, exp[15:0]});
        apb(1'b1, REG_CFG, 32'h000000D4);
        cmd(C_SOFT_WR);
        cmp({12'h000, mcfg}, 32'h000000D4);
        cmp({rd[3], msoft}, 2'h3);
        apb(1'b1, REG_CMD, {29'h0, C_SLEEP});
        wait_st(ST_ASLEEP, 1'b1, 300);
        cmp({31'h0, mpar}, 32'h0);
        cmd(C_WAKE);
        apb(1'b1, REG_CFG, 32'h00000060);
        cmd(C_SOFT_WR);
        cmp({rd[ST_REFUSED], mcfg}, {1'b1, 20'h000D4});
        apb(1'b1, REG_STATUS, 32'h00000010);
        cmd(C_PIN_LOAD);
        cmp({12'h000, mcfg}, 32'h00000060);
        apb(1'b1, REG_CMD, {29'h0, C_SLEEP});
        wait_st(ST_ASLEEP, 1'b1, 300);
        cmp({31'h0, mdpd}, 32'h1);
        cmp({31'h0, rd[ST_INVALID]}, 32'h1);
        apb(1'b1, REG_CMD, {29'h0, C_WAKE});
        wait_st(ST_INIT, 1'b1, 5);
        wait_st(ST_BUSY, 1'b0, 100);
        apb(1'b1, REG_ADDR, 32'h00000123);
        cmd(C_MEM_RD);
        apb(1'b0, REG_RDATA, 32'h0);
        cmp(rd, 32'h0000FEDC);
        val = 20'($random(seed));
        apb(1'b1, REG_WDATA, {12'h000, val});
        cmd(C_MEM_WR);
        cmp({16'h0, mwl}, {16'h0, val[15:0]});
        cmp(mearly, 32'h0);
        end_of_test;
    end
endmodule
